// >>> logic/input_output_port_pair.v
// Input port, output port, control and level-change interrupt over AHB-Lite
// ============================================================
// Summary of operation
// - The input level register is read-only and shows each pin, 1 high.
// - A 4-bit output data register drives the four output pins.
// - Reset clears the output data register to zero.
// - Written output data reaches the pins in the second half of a state.
// - Read data is latched mid-state, before the data phase answers.
// - Input pins share one mode: pull-up, pull-down or high impedance.
// - Output pins share one drive: push-pull or open drain.
// - A change in the OR of input levels raises an interrupt request when unmasked.
// - The two lowest input pins feed the capture trigger outputs.
// - Input mode bit 1 gives high impedance, 0 connects a pull.
// - Pull direction bit 1 pulls down, 0 pulls up, reset value 0.
// - Drive bit 1 gives open drain, 0 push-pull, reset value 0.
// - OR of input pins sampled at each 64 Hz tick; a change sets flag.
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "port_pair_regs.vh"
module input_output_port_pair #(
    parameter integer SAMPLE_CYCLES = `SAMPLE_CYCLES
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output reg [31:0] hrdata,
    output wire hresp,
    input wire [3:0] in_pins,
    output wire [3:0] out_pins_o,
    output wire [3:0] out_pins_oe_n,
    output wire pull_up_en,
    output wire pull_down_en,
    output wire [1:0] capture_trigger,
    output wire irq
);
    // ============================================================
    // Synchroniser and divider
    reg [3:0] sync1_q;
    reg [3:0] sync2_q;
    wire sample_tick;
    wire half_tick;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
        end else begin
            sync1_q <= in_pins;
            sync2_q <= sync1_q;
        end
    end

    sample_tick_gen #(
        .SAMPLE_CYCLES(SAMPLE_CYCLES),
        .STATE_CYCLES(`MC_STATE_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .sample_tick(sample_tick),
        .half_tick(half_tick)
    );

    // ============================================================
    // Bus slave: one-hot phase machine
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_DONE = 4'b0100;
    localparam [3:0] ST_RESV = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg [11:0] addr_q;
    reg write_q;
    reg [3:0] out_data_q;
    reg [2:0] ctl_q;
    reg status_q;
    reg mask_q;
    reg last_or_q;
    reg [3:0] out_pend_q;
    reg out_pend_v_q;

    wire take = hsel && hready && htrans[1];
    wire level_or = |sync2_q;
    wire level_event = sample_tick && (level_or != last_or_q);
    wire status_rd = (state_q == ST_WAIT) && half_tick && !write_q &&
        (addr_q == `ADDR_IRQ_STATUS);

    function [31:0] read_mux;
        input [11:0] a;
        begin
            case (a)
                `ADDR_INPUT_PIN_LEVELS: read_mux = {28'h0, sync2_q};
                `ADDR_OUTPUT_PORT_DATA: read_mux = {28'h0, out_data_q};
                `ADDR_PORT_PAIR_CONTROL: read_mux = {29'h0, ctl_q};
                `ADDR_IRQ_STATUS: read_mux = {31'h0, status_q};
                `ADDR_IRQ_MASK: read_mux = {31'h0, mask_q};
                default: read_mux = 32'h0;
            endcase
        end
    endfunction

    always @* begin
        case (state_q)
            ST_IDLE: state_d = take ? ST_WAIT : ST_IDLE;
            // Wait for mid-state strobe, so answers align with states
            ST_WAIT: state_d = half_tick ? ST_DONE : ST_WAIT;
            ST_DONE: state_d = take ? ST_WAIT : ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    assign hreadyout = (state_q != ST_WAIT);
    assign hresp = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
            addr_q <= 12'h0;
            write_q <= 1'b0;
            hrdata <= 32'h0;
            out_data_q <= `OUT_DATA_RESET;
            ctl_q <= `CTL_RESET;
            mask_q <= `IRQ_MASK_RESET;
            out_pend_q <= 4'h0;
            out_pend_v_q <= 1'b0;
        end else begin
            state_q <= state_d;
            // Pending data lands even while another transfer waits
            if (out_pend_v_q && half_tick) begin
                out_data_q <= out_pend_q;
                out_pend_v_q <= 1'b0;
            end
            if (take && state_q != ST_WAIT) begin
                addr_q <= haddr;
                write_q <= hwrite;
            end
            if (state_q == ST_WAIT && half_tick) begin
                if (!write_q)
                    hrdata <= read_mux(addr_q);
                else begin
                    case (addr_q)
                        `ADDR_OUTPUT_PORT_DATA: begin
                            out_pend_q <= hwdata[3:0];
                            out_pend_v_q <= 1'b1;
                        end
                        `ADDR_PORT_PAIR_CONTROL: ctl_q <= hwdata[2:0];
                        `ADDR_IRQ_MASK: mask_q <= hwdata[0];
                        default: ;
                    endcase
                end
            end
        end
    end

    // ============================================================
    // Level change interrupt
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            last_or_q <= 1'b0;
            status_q <= 1'b0;
        end else begin
            if (sample_tick)
                last_or_q <= level_or;
            // Set wins over read-clear
            if (level_event)
                status_q <= 1'b1;
            else if (status_rd)
                status_q <= 1'b0;
        end
    end

    assign irq = status_q & mask_q;

    // ============================================================
    // Pad controls
    wire hiz_mode = ctl_q[`CTL_INPUT_MODE_BIT];
    wire pull_dn = ctl_q[`CTL_PULL_DIR_BIT];
    wire open_drain = ctl_q[`CTL_OUTPUT_DRIVE_BIT];

    assign pull_up_en = !hiz_mode && !pull_dn;
    assign pull_down_en = !hiz_mode && pull_dn;
    assign out_pins_o = open_drain ? 4'h0 : out_data_q;
    // Open drain only drives for a zero bit
    assign out_pins_oe_n = open_drain ? out_data_q : 4'h0;
    assign capture_trigger = sync2_q[1:0];
endmodule // input_output_port_pair
`default_nettype wire

// >>> logic/port_pair_regs.vh
// Register offsets, fields, reset values and timing counts of the port pair
`ifndef PORT_PAIR_REGS_VH
`define PORT_PAIR_REGS_VH

// ============================================================
// Register byte addresses (printed offsets not all word aligned)
`define IDX_INPUT_PIN_LEVELS 8'h03
`define IDX_OUTPUT_PORT_DATA 8'h01
`define IDX_PORT_PAIR_CONTROL 8'h04
`define IDX_IRQ_STATUS 8'h05
`define IDX_IRQ_MASK 8'h06
`define ADDR_INPUT_PIN_LEVELS 12'h00C
`define ADDR_OUTPUT_PORT_DATA 12'h004
`define ADDR_PORT_PAIR_CONTROL 12'h010
`define ADDR_IRQ_STATUS 12'h014
`define ADDR_IRQ_MASK 12'h018

// ============================================================
// Control fields
`define CTL_INPUT_MODE_BIT 0
`define CTL_OUTPUT_DRIVE_BIT 1
`define CTL_PULL_DIR_BIT 2
`define CTL_RESET 3'h0
`define OUT_DATA_RESET 4'h0
`define IRQ_LEVEL_BIT 0
`define IRQ_MASK_RESET 1'h0

// ============================================================
// Timing
`define CLK_PERIOD_NS 10
`define SAMPLE_RATE_HZ 64
`define SAMPLE_CYCLES (1000000000 / (`SAMPLE_RATE_HZ * `CLK_PERIOD_NS))
`define MC_STATE_CYCLES 4

`endif

// >>> logic/sample_tick_gen.v
// Divider making the 64 Hz one-cycle sampling strobe and state phases
`timescale 1ns/1ps
`default_nettype none
module sample_tick_gen #(
    parameter integer SAMPLE_CYCLES = 1562500,
    parameter integer STATE_CYCLES = 4
) (
    input wire hclk,
    input wire hresetn,
    output reg sample_tick,
    output reg half_tick
);
    reg [31:0] cnt_q;
    reg [7:0] phase_q;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 32'h0;
            phase_q <= 8'h0;
            sample_tick <= 1'b0;
            half_tick <= 1'b0;
        end else begin
            sample_tick <= (cnt_q == SAMPLE_CYCLES - 1);
            if (cnt_q == SAMPLE_CYCLES - 1)
                cnt_q <= 32'h0;
            else
                cnt_q <= cnt_q + 32'h1;
            // Second half of a state: a mid-state strobe
            half_tick <= (phase_q == STATE_CYCLES / 2 - 1);
            if (phase_q == STATE_CYCLES - 1)
                phase_q <= 8'h0;
            else
                phase_q <= phase_q + 8'h1;
        end
    end
endmodule // sample_tick_gen
`default_nettype wire

// >>> sim/input_output_port_pair_asserts.sv
// Port-level checker for the port pair
`timescale 1ns/1ps
`default_nettype none
module input_output_port_pair_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [3:0] in_pins,
    input wire logic [3:0] out_pins_o,
    input wire logic [3:0] out_pins_oe_n,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic [1:0] capture_trigger
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence pins_settled; $stable(in_pins) [*3]; endsequence
    sequence wait_starts; $fell(hreadyout); endsequence
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("error response");
    chk_wait_bound: assert property (wait_starts |-> ##[1:4] hreadyout)
        else $error("wait too long");
    chk_out_reset: assert property ($rose(hresetn) |-> out_pins_o == 4'h0)
        else $error("output not cleared");
    chk_upper_zero: assert property (hrdata[31:4] == 28'h0)
        else $error("upper read bits set");
    chk_pull_excl: assert property (!(pull_up_en && pull_down_en))
        else $error("both pulls on");
    chk_drive_shared: assert property
        (out_pins_oe_n == 4'h0 || out_pins_o == 4'h0)
        else $error("mixed drive");
    chk_release_ones: assert property ((out_pins_oe_n != 4'h0) |->
        ((out_pins_o & ~out_pins_oe_n) == 4'h0))
        else $error("zero released");
    chk_capture_sync: assert property
        (pins_settled |-> capture_trigger == in_pins[1:0])
        else $error("capture mismatch");
endmodule // input_output_port_pair_asserts
bind input_output_port_pair input_output_port_pair_asserts u_chk (.hclk,
    .hresetn, .hreadyout, .hrdata, .hresp, .in_pins, .out_pins_o,
    .out_pins_oe_n, .pull_up_en, .pull_down_en, .capture_trigger);
`default_nettype wire

// >>> sim/port_pins_model.sv
// External equipment on the input and output pins
`timescale 1ns/1ps
`default_nettype none
module port_pins_model (
    input wire logic hclk,
    input wire logic ext_drive,
    input wire logic [3:0] ext_val,
    input wire logic pull_up_en,
    input wire logic pull_down_en,
    input wire logic [3:0] out_pins_o,
    input wire logic [3:0] out_pins_oe_n,
    output logic [3:0] in_pins,
    output logic [3:0] out_level
);
    logic [3:0] wander_q = 4'h5;
    // Floating pins churn so no stale level passes for a pull
    always @(posedge hclk) wander_q <= ~wander_q;
    always_comb begin
        if (ext_drive) in_pins = ext_val;
        else if (pull_up_en) in_pins = 4'hF;
        else if (pull_down_en) in_pins = 4'h0;
        else in_pins = wander_q;
    end
    // Board pull-up lifts a released open-drain pin
    assign out_level = out_pins_o | out_pins_oe_n;
endmodule // port_pins_model
`default_nettype wire

// >>> sim/test_input_output_port_pair.sv
// Self-checking bench for the port pair
`timescale 1ns/1ps
`default_nettype none
`include "port_pair_regs.vh"
module test_input_output_port_pair;
    localparam int SC = 20;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_drive = 1;
    logic [11:0] haddr = 12'h0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, r;
    logic [3:0] ext_val = 4'h0, in_pins, out_pins_o, out_pins_oe_n, out_level;
    logic hreadyout, hresp, pull_up_en, pull_down_en, irq;
    logic [1:0] capture_trigger;
    int n_mismatch = 0, checked = 0;
    input_output_port_pair #(.SAMPLE_CYCLES(SC)) u_input_output_port_pair (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .in_pins,
        .out_pins_o, .out_pins_oe_n, .pull_up_en, .pull_down_en,
        .capture_trigger, .irq);
    port_pins_model u_port_pins_model (.hclk, .ext_drive, .ext_val,
        .pull_up_en, .pull_down_en, .out_pins_o, .out_pins_oe_n, .in_pins,
        .out_level);
    always #5 hclk = ~hclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        {hsel, htrans, hwrite} <= {1'h1, 2'h2, w};
        haddr <= a;
        // Look at ready before the edge, not in the edge's own time step
        do @(negedge hclk); while (hreadyout !== 1'h1);
        @(posedge hclk);
        {hsel, htrans} <= 3'h0;
        hwdata <= d;
        do @(negedge hclk); while (hreadyout !== 1'h1);
        r = hrdata;
        @(posedge hclk);
    endtask
    task automatic results;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        results;
    end
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'h1;
        chk({pull_up_en, pull_down_en, out_pins_oe_n}, 6'h20);
        xfer(0, `ADDR_OUTPUT_PORT_DATA, 32'h0);
        chk(r, 32'h0);
        xfer(1, `ADDR_OUTPUT_PORT_DATA, 32'hA);
        repeat (2) @(posedge hclk);
        chk(out_level, 4'h0);
        repeat (4) @(posedge hclk);
        chk(out_level, 4'hA);
        xfer(0, `ADDR_OUTPUT_PORT_DATA, 32'h0);
        chk(r, 32'hA);
        xfer(1, `ADDR_PORT_PAIR_CONTROL, 32'h2);
        repeat (2) @(posedge hclk);
        chk({out_pins_oe_n, out_level}, 8'hAA);
        ext_val <= 4'h5;
        repeat (4) @(posedge hclk);
        chk(capture_trigger, 2'h1);
        xfer(1, `ADDR_INPUT_PIN_LEVELS, 32'hF);
        xfer(0, `ADDR_INPUT_PIN_LEVELS, 32'h0);
        chk(r, 32'h5);
        xfer(0, 12'h020, 32'h0);
        chk(r, 32'h0);
        ext_drive <= 1'h0;
        xfer(1, `ADDR_PORT_PAIR_CONTROL, 32'h4);
        repeat (4) @(posedge hclk);
        xfer(0, `ADDR_INPUT_PIN_LEVELS, 32'h0);
        chk({r[3:0], pull_up_en, pull_down_en}, 6'h01);
        xfer(1, `ADDR_PORT_PAIR_CONTROL, 32'h1);
        @(posedge hclk);
        chk({pull_up_en, pull_down_en}, 2'h0);
        ext_drive <= 1'h1;
        ext_val <= 4'h0;
        xfer(1, `ADDR_IRQ_MASK, 32'h1);
        repeat (3 * SC) @(posedge hclk);
        xfer(0, `ADDR_IRQ_STATUS, 32'h0);
        ext_val <= 4'h8;
        repeat (3 * SC) @(posedge hclk);
        chk(irq, 1'h1);
        xfer(0, `ADDR_IRQ_STATUS, 32'h0);
        chk(r, 32'h1);
        ext_val <= 4'h1;
        repeat (3 * SC) @(posedge hclk);
        chk(irq, 1'h0);
        xfer(1, `ADDR_IRQ_MASK, 32'h0);
        ext_val <= 4'h0;
        repeat (3 * SC) @(posedge hclk);
        chk(irq, 1'h0);
        xfer(0, `ADDR_IRQ_STATUS, 32'h0);
        chk(r, 32'h1);
        results;
    end
endmodule // test_input_output_port_pair
`default_nettype wire
